// File: include/cbt_pkg.sv
// Package: timing, register map and states for the training controller
package cbt_pkg;
   localparam int unsigned CLK_PERIOD_PS  = 10000;
   // Times in picoseconds, as specified; the NCK values and DQS_PULSES are counts
   localparam int unsigned T_CKELCK_PS    = 5000;
   localparam int unsigned T_CKELCK_NCK   = 3;
   localparam int unsigned T_DQSCKE_PS    = 10000;
   localparam int unsigned T_CAENT_PS     = 250000;
   localparam int unsigned T_VREF_LONG_PS = 250000;
   localparam int unsigned T_ADR_PS       = 20000;
   localparam int unsigned T_CKCKEH_PS    = 1750;
   localparam int unsigned T_CKCKEH_NCK   = 3;
   localparam int unsigned T_XCBT_PS      = 200000;
   localparam int unsigned T_XCBT_NCK     = 5;
   localparam int unsigned T_CS_VREF_NCK  = 2;
   localparam int unsigned DQS_PULSES     = 2;

   function automatic int unsigned cyc_min(input int unsigned ps, input int unsigned nck);
      int unsigned c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      if (c < nck) c = nck;
      if (c < 1) c = 1;
      return c;
   endfunction

   // Counts in mclk cycles, rounded up from picoseconds by CLK_PERIOD_PS; DQS_HALF_CYC is set directly
   localparam int unsigned CKELCK_CYC   = cyc_min(T_CKELCK_PS, 0);
   localparam int unsigned DQSCKE_CYC   = cyc_min(T_DQSCKE_PS, 0);
   localparam int unsigned CAENT_CYC    = cyc_min(T_CAENT_PS, 0);
   localparam int unsigned VREF_CYC     = cyc_min(T_VREF_LONG_PS, 0);
   localparam int unsigned ADR_CYC      = cyc_min(T_ADR_PS, 0);
   localparam int unsigned CKCKEH_CYC   = cyc_min(T_CKCKEH_PS, 0);
   localparam int unsigned XCBT_CYC     = cyc_min(T_XCBT_PS, 0);
   localparam int unsigned DQS_HALF_CYC = 4;

   // Own register map (byte addresses)
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] VREF_OFS   = 8'h04;
   localparam logic [7:0] CMD_OFS    = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] SAMPLE_OFS = 8'h10;
   // CTRL bits
   localparam int unsigned CTRL_ENTER = 0;
   localparam int unsigned CTRL_EXIT  = 1;
   localparam int unsigned CTRL_VREF  = 2;
   localparam int unsigned CTRL_CMD   = 3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE, ST_STROBE, ST_CKELOW, ST_ENTWAIT, ST_READY, ST_VDRIVE, ST_VPULSE,
      ST_VSETTLE, ST_CSWAIT, ST_CSHIGH, ST_CACD, ST_PREEXIT, ST_EXITWAIT
   } cbt_state_t;
endpackage

// File: hw/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t st_reg;
   sync_t st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule // sync2

// File: hw/cbt_ctrl.sv
// Command bus training controller with AXI4-Lite control registers
`timescale 1ns/1ps
module cbt_ctrl #(
   parameter int unsigned VREF_W = 7,
   parameter int unsigned CA_W   = 6
) (
   input  wire logic              mclk,
   input  wire logic              srst,
   input  wire logic              ce,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              link_ck,
   output logic                   cke,
   output logic                   cs,
   output logic [CA_W-1:0]        ca,
   output logic                   dqs_t,
   output logic                   dqs_c,
   output logic [VREF_W-1:0]      dq_lo_out,
   output logic                   dq_lo_oe_n,
   input  wire logic [CA_W-1:0]   dq_echo_in
);
   typedef struct packed {
      cbt_pkg::cbt_state_t st;
      logic [15:0]         cnt;
      logic [2:0]          pulses;
      logic                mode_ok;
      logic                cmd_req;
      logic                vref_req;
      logic                exit_req;
      logic                done_seen;
      logic [VREF_W-1:0]   vref_val;
      logic [CA_W-1:0]     ca_val;
      logic [CA_W-1:0]     sample;
      logic                sample_vld;
      logic                ck_prev;
      logic                cke_o;
      logic                cs_o;
      logic                dqs_o;
      logic                dq_oe_n;
      logic                aw_hit;
      logic                w_hit;
      logic [7:0]          awaddr;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
   } ctl_t;
   ctl_t r_reg;
   ctl_t r_next;

   logic                ck_s;
   logic [CA_W-1:0]     echo_s;
   logic                ck_rise;
   logic                wr_ctrl;

   sync2 #(.W(1)) u_ck_sync (.mclk(mclk), .srst(srst), .ce(ce), .d(link_ck), .q(ck_s));
   sync2 #(.W(CA_W)) u_echo_sync (.mclk(mclk), .srst(srst), .ce(ce), .d(dq_echo_in),
                                  .q(echo_s));

   assign ck_rise = ck_s & ~r_reg.ck_prev;
   // Control word landing this cycle; a new order must not be lost to a clear
   assign wr_ctrl = r_reg.aw_hit && r_reg.w_hit && !r_reg.bvalid &&
                    r_reg.awaddr == cbt_pkg::CTRL_OFS && r_reg.wstrb[0];

   function automatic logic [15:0] c16(input int unsigned v);
      return v[15:0];
   endfunction

   always_comb begin
      r_next         = r_reg;
      r_next.ck_prev = ck_s;
      // Write channel: address and data taken in either order
      if (s_axi_awvalid && !r_reg.aw_hit) begin
         r_next.aw_hit = 1'b1;
         r_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r_reg.w_hit) begin
         r_next.w_hit = 1'b1;
         r_next.wdata = s_axi_wdata;
         r_next.wstrb = s_axi_wstrb;
      end
      if (r_reg.aw_hit && r_reg.w_hit && !r_reg.bvalid) begin
         r_next.aw_hit = 1'b0;
         r_next.w_hit  = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp  = cbt_pkg::RESP_OKAY;
         unique case (r_reg.awaddr)
            cbt_pkg::CTRL_OFS: begin
               if (r_reg.wstrb[0]) begin
                  // Software has set the training bit before ordering entry
                  if (r_reg.wdata[cbt_pkg::CTRL_ENTER]) r_next.mode_ok = 1'b1;
                  if (r_reg.wdata[cbt_pkg::CTRL_EXIT]) r_next.exit_req = 1'b1;
                  if (r_reg.wdata[cbt_pkg::CTRL_VREF]) r_next.vref_req = 1'b1;
                  if (r_reg.wdata[cbt_pkg::CTRL_CMD]) r_next.cmd_req = 1'b1;
               end
            end
            cbt_pkg::VREF_OFS: if (r_reg.wstrb[0]) r_next.vref_val = r_reg.wdata[VREF_W-1:0];
            cbt_pkg::CMD_OFS: if (r_reg.wstrb[0]) r_next.ca_val = r_reg.wdata[CA_W-1:0];
            cbt_pkg::STATUS_OFS, cbt_pkg::SAMPLE_OFS: ;
            default: r_next.bresp = cbt_pkg::RESP_SLVERR;
         endcase
      end
      if (r_reg.bvalid && s_axi_bready) r_next.bvalid = 1'b0;
      // Read channel
      if (s_axi_arvalid && !r_reg.rvalid) begin
         r_next.rvalid = 1'b1;
         r_next.rresp  = cbt_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            cbt_pkg::CTRL_OFS: r_next.rdata = {31'h0, r_reg.mode_ok};
            cbt_pkg::VREF_OFS: r_next.rdata = {{(32-VREF_W){1'b0}}, r_reg.vref_val};
            cbt_pkg::CMD_OFS: r_next.rdata = {{(32-CA_W){1'b0}}, r_reg.ca_val};
            cbt_pkg::STATUS_OFS: r_next.rdata = {24'h0, r_reg.sample_vld, r_reg.done_seen,
                                                 r_reg.cke_o, 1'b0, r_reg.st};
            cbt_pkg::SAMPLE_OFS: r_next.rdata = {{(32-CA_W){1'b0}}, r_reg.sample};
            default: begin
               r_next.rdata = 32'h0;
               r_next.rresp = cbt_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (r_reg.rvalid && s_axi_rready) r_next.rvalid = 1'b0;

      // Training sequencer; counts in mclk cycles
      if (r_reg.cnt != 16'h0) r_next.cnt = r_reg.cnt - 16'h1;
      unique case (r_reg.st)
         cbt_pkg::ST_IDLE: begin
            r_next.cke_o   = 1'b1;
            r_next.dq_oe_n = 1'b1;
            if (r_reg.mode_ok) begin
               r_next.mode_ok = wr_ctrl && r_reg.wdata[cbt_pkg::CTRL_ENTER];
               r_next.dqs_o   = 1'b0;
               r_next.dq_oe_n = 1'b0;
               r_next.cnt     = c16(cbt_pkg::DQSCKE_CYC);
               r_next.st      = cbt_pkg::ST_STROBE;
            end
         end
         cbt_pkg::ST_STROBE: if (r_reg.cnt == 16'h0) begin
            // Strobe held low long enough, now drop CKE
            r_next.cke_o = 1'b0;
            r_next.cs_o  = 1'b0;
            r_next.cnt   = c16(cbt_pkg::CAENT_CYC);
            r_next.st    = cbt_pkg::ST_ENTWAIT;
         end
         cbt_pkg::ST_ENTWAIT: begin
            // CAENT far exceeds CKELCK, so clock and CS low hold both here
            r_next.cs_o = 1'b0;
            if (r_reg.cnt == 16'h0) r_next.st = cbt_pkg::ST_READY;
         end
         cbt_pkg::ST_READY: begin
            if (r_reg.exit_req) begin
               r_next.exit_req = wr_ctrl && r_reg.wdata[cbt_pkg::CTRL_EXIT];
               r_next.cnt      = c16(cbt_pkg::CKCKEH_CYC);
               r_next.st       = cbt_pkg::ST_PREEXIT;
            end else if (r_reg.vref_req) begin
               r_next.vref_req = wr_ctrl && r_reg.wdata[cbt_pkg::CTRL_VREF];
               r_next.pulses   = 3'h0;
               // CS has been low for many cycles by the time READY is reached
               r_next.cnt      = c16(cbt_pkg::DQS_HALF_CYC);
               r_next.st       = cbt_pkg::ST_VDRIVE;
            end else if (r_reg.cmd_req) begin
               r_next.cmd_req    = wr_ctrl && r_reg.wdata[cbt_pkg::CTRL_CMD];
               r_next.sample_vld = 1'b0;
               r_next.st         = cbt_pkg::ST_CSWAIT;
            end
         end
         cbt_pkg::ST_VDRIVE: if (r_reg.cnt == 16'h0) begin
            r_next.dqs_o = ~r_reg.dqs_o;
            r_next.cnt   = c16(cbt_pkg::DQS_HALF_CYC);
            if (r_reg.dqs_o) begin
               r_next.pulses = r_reg.pulses + 3'h1;
               // First edge may be lost, so always send two pulses
               if (r_reg.pulses + 3'h1 >= 3'(cbt_pkg::DQS_PULSES)) begin
                  r_next.cnt = c16(cbt_pkg::VREF_CYC);
                  r_next.st  = cbt_pkg::ST_VSETTLE;
               end
            end
         end
         cbt_pkg::ST_VSETTLE: if (r_reg.cnt == 16'h0) begin
            // Always waits the long settle; short is never assumed
            r_next.st = cbt_pkg::ST_READY;
         end
         cbt_pkg::ST_CSWAIT: if (ck_rise) begin
            r_next.cs_o = 1'b1;
            r_next.st   = cbt_pkg::ST_CSHIGH;
         end
         cbt_pkg::ST_CSHIGH: if (ck_rise) begin
            r_next.cs_o = 1'b0;
            r_next.cnt  = c16(cbt_pkg::ADR_CYC + 2);
            r_next.st   = cbt_pkg::ST_CACD;
         end
         cbt_pkg::ST_CACD: if (r_reg.cnt == 16'h0) begin
            // Echo sampled only after tADR plus the synchroniser
            r_next.sample     = echo_s;
            r_next.sample_vld = 1'b1;
            r_next.st         = cbt_pkg::ST_READY;
         end
         cbt_pkg::ST_PREEXIT: begin
            r_next.cs_o = 1'b0;
            if (r_reg.cnt == 16'h0) begin
               r_next.cke_o   = 1'b1;
               r_next.dq_oe_n = 1'b1;
               r_next.cnt     = c16(cbt_pkg::XCBT_CYC);
               r_next.st      = cbt_pkg::ST_EXITWAIT;
            end
         end
         cbt_pkg::ST_EXITWAIT: if (r_reg.cnt == 16'h0) begin
            // Trained values are lost; software must write them back
            r_next.done_seen = 1'b1;
            r_next.st        = cbt_pkg::ST_IDLE;
         end
         default: r_next.st = cbt_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         r_reg       <= '0;
         r_reg.cke_o <= 1'b1;
         r_reg.dq_oe_n <= 1'b1;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign s_axi_awready = ~r_reg.aw_hit;
   assign s_axi_wready  = ~r_reg.w_hit;
   assign s_axi_bvalid  = r_reg.bvalid;
   assign s_axi_bresp   = r_reg.bresp;
   assign s_axi_arready = ~r_reg.rvalid;
   assign s_axi_rvalid  = r_reg.rvalid;
   assign s_axi_rdata   = r_reg.rdata;
   assign s_axi_rresp   = r_reg.rresp;
   assign cke           = r_reg.cke_o;
   assign cs            = r_reg.cs_o;
   assign ca            = r_reg.ca_val;
   assign dqs_t         = r_reg.dqs_o;
   assign dqs_c         = ~r_reg.dqs_o;
   assign dq_lo_out     = r_reg.vref_val;
   assign dq_lo_oe_n    = r_reg.dq_oe_n;

   a_strobe_before_cke: assert property (@(posedge mclk) disable iff (srst)
      $fell(cke) |-> $past(dqs_t) == 1'b0 && $past(dqs_c) == 1'b1)
      else $error("strobe not low before cke fall");
   a_cs_low_after_cke: assert property (@(posedge mclk) disable iff (srst)
      $fell(cke) |-> !cs [*8])
      else $error("cs raised too soon after cke fall");
   a_entry_wait: assert property (@(posedge mclk) disable iff (srst)
      $fell(cke) |=> r_reg.st == cbt_pkg::ST_ENTWAIT)
      else $error("entry wait skipped");
   a_two_pulses: assert property (@(posedge mclk) disable iff (srst)
      r_reg.st == cbt_pkg::ST_VSETTLE |-> r_reg.pulses >= 3'h2)
      else $error("fewer than two dqs pulses");
   a_cs_before_exit: assert property (@(posedge mclk) disable iff (srst)
      $rose(cke) |-> !$past(cs) && !$past(cs, 2))
      else $error("cs high before cke rise");
   a_exit_wait: assert property (@(posedge mclk) disable iff (srst || !ce)
      $rose(cke) |-> r_reg.st != cbt_pkg::ST_IDLE [*8])
      else $error("exit wait too short");
   a_cmd_spacing: assert property (@(posedge mclk) disable iff (srst)
      $fell(cs) && !cke |=> r_reg.st == cbt_pkg::ST_CACD)
      else $error("command spacing skipped");
   a_no_cs_outside: assert property (@(posedge mclk) disable iff (srst)
      cs |-> !cke)
      else $error("training cs with cke high");
   a_dqs_after_cs: assert property (@(posedge mclk) disable iff (srst)
      $rose(dqs_t) |-> !cs && !$past(cs) && !$past(cs, 2))
      else $error("dqs toggled too soon after cs");
   a_clock_before_exit: assert property (@(posedge mclk) disable iff (srst)
      $rose(cke) |-> $past(r_reg.st) == cbt_pkg::ST_PREEXIT)
      else $error("cke raised without pre-exit hold");
   a_frozen_state: assert property (@(posedge mclk) disable iff (srst)
      !ce |=> $stable(r_reg))
      else $error("state moved while clock enable low");
   a_dq_driven: assert property (@(posedge mclk) disable iff (srst)
      !cke |-> !dq_lo_oe_n)
      else $error("reference lines released during training");
   a_cs_width: assert property (@(posedge mclk) disable iff (srst || !ce)
      $rose(cs) |-> cs [*8])
      else $error("cs pulse shorter than a link clock");
   a_sample_late: assert property (@(posedge mclk) disable iff (srst)
      $rose(r_reg.sample_vld) |-> $past(r_reg.st) == cbt_pkg::ST_CACD)
      else $error("sample taken before echo delay");
   c_freeze: cover property (@(posedge mclk) !ce && r_reg.st == cbt_pkg::ST_VDRIVE);
   c_entry: cover property (@(posedge mclk) $fell(cke));
   c_vref: cover property (@(posedge mclk) r_reg.st == cbt_pkg::ST_VSETTLE);
   c_cmd: cover property (@(posedge mclk) $rose(r_reg.sample_vld));
   c_exit: cover property (@(posedge mclk) $rose(r_reg.done_seen));
endmodule // cbt_ctrl

// File: verification/lp_mem_model.sv
// Behavioural memory device answering command bus training
`timescale 1ns/1ps
module lp_mem_model #(
   parameter logic [6:0] VREF_INIT  = 7'h1d,
   parameter logic       SETPOINT   = 1'b0,
   parameter logic       ALT_TERM   = 1'b1,
   parameter logic       PAD_GROUND = 1'b0
) (
   input  wire logic       link_ck,
   input  wire logic       cke,
   input  wire logic       cs,
   input  wire logic [5:0] ca,
   input  wire logic       dqs_t,
   input  wire logic       dqs_c,
   input  wire logic [6:0] dq_lo,
   input  wire logic       dq_lo_oe_n,
   output logic      [5:0] dq_echo
);
   logic       op_set     = SETPOINT;
   logic       term_on    = 1'b0;
   logic [6:0] vref_live  = VREF_INIT;
   logic [5:0] sample     = 6'h00;

   initial dq_echo = 6'h15;

   // Grounded pad wins over the ALT_TERM setting
   always @(negedge cke) begin
      op_set = ~SETPOINT;
      term_on <= #20 ALT_TERM & ~PAD_GROUND;
   end

   // Trained values dropped; echo lines float, shown as inverted last value
   always @(posedge cke) begin
      op_set = SETPOINT;
      vref_live  = VREF_INIT;
      term_on <= #20 1'b0;
      dq_echo <= #1.5 ~dq_echo;
   end

   // Every strobe edge overwrites; long settle always, never the short one
   always @(dqs_t) begin
      if (cke === 1'b0 && dq_lo_oe_n === 1'b0 && dqs_c === ~dqs_t) begin
         vref_live <= #250 dq_lo;
      end
   end

   // Only training samples are decoded while clock enable is low; newest wins
   always @(posedge link_ck) begin
      if (cke === 1'b0 && cs === 1'b1) begin
         sample = ca;
         dq_echo <= #15 ca;
      end
   end
endmodule // lp_mem_model

// File: verification/cbt_ctrl_test.sv
// Testbench for the training controller
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module cbt_ctrl_test;
   localparam int         TIMEOUT = 20000;
   localparam logic [6:0] VINIT   = 7'h1d;
   localparam logic [7:0] RDY     = {4'h0, cbt_pkg::ST_READY};
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        ce = 1'b1;
   logic        link_ck = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        cke, cs, dqs_t, dqs_c, dq_lo_oe_n;
   logic [5:0]  ca, dq_echo;
   logic [6:0]  dq_lo_out;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          t_fall = 0, t_rise = 0, cs_rise = -100000, cs_fall = 0, dqs_chg = 0;
   int          dqs_rises = 0;
   logic        cke_q = 1'b1, cs_q = 1'b0, dqs_q = 1'b0;
   logic [31:0] d;
   logic [1:0]  r;
   logic [6:0]  vals[2] = '{7'h2b, 7'h40};
   logic [5:0]  pats[5] = '{6'h01, 6'h2a, 6'h15, 6'h3f, 6'h00};

   always #5 mclk = ~mclk;
   // Link clock unrelated in phase to mclk
   initial begin
      #3.3;
      forever #62.5 link_ck = ~link_ck;
   end

   cbt_ctrl u_dut (.mclk(mclk), .srst(srst), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(1'b1), .link_ck(link_ck), .cke(cke), .cs(cs), .ca(ca), .dqs_t(dqs_t),
      .dqs_c(dqs_c), .dq_lo_out(dq_lo_out), .dq_lo_oe_n(dq_lo_oe_n), .dq_echo_in(dq_echo));

   lp_mem_model #(.VREF_INIT(VINIT)) u_mem (.link_ck(link_ck), .cke(cke), .cs(cs), .ca(ca),
      .dqs_t(dqs_t), .dqs_c(dqs_c), .dq_lo(dq_lo_out), .dq_lo_oe_n(dq_lo_oe_n),
      .dq_echo(dq_echo));

   task automatic complete_run;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Ready is held high, so a task may start at the edge the last one ended
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw_ok && w_ok && s_axi_bvalid));
      `CHK(s_axi_bresp, e)
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      logic ar_ok;
      ar_ok = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge mclk);
         if (!ar_ok && s_axi_arready) begin
            ar_ok = 1'b1;
            arvalid <= 1'b0;
         end
      end while (!(ar_ok && s_axi_rvalid));
      v = s_axi_rdata;
      e = s_axi_rresp;
   endtask

   task automatic wait_status(input logic [7:0] mask, input logic [7:0] val);
      logic [31:0] v;
      logic [1:0]  e;
      do axi_rd(cbt_pkg::STATUS_OFS, v, e); while ((v[7:0] & mask) !== val);
   endtask

   // Pin timing watched on every rising mclk edge; also cuts a hang short
   always @(posedge mclk) begin
      cyc++;
      if (cyc == TIMEOUT) begin
         n_mismatch++;
         complete_run();
      end
      if (!srst) begin
         if (cke_q === 1'b1 && cke === 1'b0) begin
            `CHK({dqs_t, dqs_c, dq_lo_oe_n}, 3'b010)
            `CHK(cyc - dqs_chg >= int'(cbt_pkg::DQSCKE_CYC), 1'b1)
            t_fall = cyc;
         end
         if (cke_q === 1'b0 && cke === 1'b1) begin
            `CHK(cyc - cs_fall >= int'(cbt_pkg::CKCKEH_CYC) && !cs, 1'b1)
            t_rise = cyc;
         end
         if (cs_q === 1'b0 && cs === 1'b1) begin
            `CHK(cyc - t_fall >= int'(cbt_pkg::CAENT_CYC), 1'b1)
            `CHK(cyc - cs_rise >= int'(cbt_pkg::ADR_CYC), 1'b1)
            cs_rise = cyc;
         end
         if (cs_q === 1'b1 && cs === 1'b0) cs_fall = cyc;
         if (dqs_t !== dqs_q) begin
            dqs_chg = cyc;
            if (dqs_t === 1'b1) dqs_rises++;
         end
      end
      cke_q = cke;
      cs_q = cs;
      dqs_q = dqs_t;
   end

   initial begin
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      `CHK({cke, cs, dqs_t, dqs_c, dq_lo_oe_n}, 5'b10011)
      axi_wr(8'h20, 32'h1, cbt_pkg::RESP_SLVERR);
      axi_rd(8'h20, d, r);
      `CHK({r, d}, {cbt_pkg::RESP_SLVERR, 32'h0})
      axi_wr(cbt_pkg::VREF_OFS, 32'h2a, cbt_pkg::RESP_OKAY);
      axi_rd(cbt_pkg::VREF_OFS, d, r);
      `CHK(d[6:0], 7'h2a)
      axi_wr(cbt_pkg::CTRL_OFS, 32'h1 << cbt_pkg::CTRL_ENTER, cbt_pkg::RESP_OKAY);
      wait_status(8'h2f, RDY);
      `CHK({u_mem.op_set, dq_lo_oe_n}, 2'b10)
      foreach (vals[i]) begin
         axi_wr(cbt_pkg::VREF_OFS, {25'h0, vals[i]}, cbt_pkg::RESP_OKAY);
         dqs_rises = 0;
         axi_wr(cbt_pkg::CTRL_OFS, 32'h1 << cbt_pkg::CTRL_VREF, cbt_pkg::RESP_OKAY);
         wait_status(8'h0f, RDY);
         `CHK(dqs_rises, int'(cbt_pkg::DQS_PULSES))
         `CHK({dq_lo_out, u_mem.vref_live}, {vals[i], vals[i]})
      end
      // Clock enable low must hold the strobe sequence where it stands
      dqs_rises = 0;
      axi_wr(cbt_pkg::CTRL_OFS, 32'h1 << cbt_pkg::CTRL_VREF, cbt_pkg::RESP_OKAY);
      ce <= 1'b0;
      repeat (40) @(posedge mclk);
      `CHK(dqs_rises, 0)
      ce <= 1'b1;
      wait_status(8'h0f, RDY);
      `CHK(dqs_rises, int'(cbt_pkg::DQS_PULSES))
      foreach (pats[i]) begin
         axi_wr(cbt_pkg::CMD_OFS, {26'h0, pats[i]}, cbt_pkg::RESP_OKAY);
         axi_wr(cbt_pkg::CTRL_OFS, 32'h1 << cbt_pkg::CTRL_CMD, cbt_pkg::RESP_OKAY);
         wait_status(8'h8f, 8'h80 | RDY);
         axi_rd(cbt_pkg::SAMPLE_OFS, d, r);
         `CHK(d[5:0], pats[i])
      end
      axi_wr(cbt_pkg::CTRL_OFS, 32'h1 << cbt_pkg::CTRL_EXIT, cbt_pkg::RESP_OKAY);
      wait_status(8'h60, 8'h60);
      `CHK(cyc - t_rise >= int'(cbt_pkg::XCBT_CYC), 1'b1)
      `CHK({cke, dq_lo_oe_n}, 2'b11)
      `CHK({u_mem.op_set, u_mem.vref_live}, {1'b0, VINIT})
      complete_run();
   end
endmodule // cbt_ctrl_test
